// ### src/fopc_top.sv
// Flash operation control: APB register, boot-bank alias swap and operation issue.
`timescale 1ns/10ps
module fopc_top (
   // Clock and reset.
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // APB slave.
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Neighbouring registers, same clock.
   input  wire logic                        write_enable,
   input  wire logic                        unlocked,
   input  wire logic [31:0]                 flash_address,
   input  wire logic [fopc_pkg::FOPC_PP_W-1:0] page_protect,
   input  wire logic [1:0]                  dynamic_ecc_config,
   input  wire logic                        op_start,
   // Flash array side.
   output logic                             lower_alias_bank2,
   output logic                             upper_alias_bank2,
   output logic [2:0]                       flash_action,
   output logic                             flash_go,
   output logic                             ecc_bypass,
   output logic                             op_blocked
);
   import fopc_pkg::*;

   logic [3:0]  op_q;
   logic        swap_q;
   logic        acc;
   logic        wr;
   fopc_act_t   act;
   logic        ecc_skip;
   logic        blocked;

   // APB access phase; the slave answers with zero wait states.
   assign acc = psel & penable;
   assign wr  = acc & pwrite & (paddr == FOPC_CTRL_OFS);

   // Operation field, frozen while write enable is set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q <= FOPC_OP_RST;
      end else if (wr && !write_enable) begin
         op_q <= pwdata[FOPC_OP_MSB:FOPC_OP_LSB];
      end
   end

   // Swap bit needs both write enable clear and the unlock sequence.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swap_q <= FOPC_SWAP_RST;
      end else if (wr && !write_enable && unlocked) begin
         swap_q <= pwdata[FOPC_SWAP_BIT];
      end
   end

   // Read mux; bits 5 and 4 are never stored so they read zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            if (paddr == FOPC_CTRL_OFS) begin
               prdata[FOPC_OP_MSB:FOPC_OP_LSB] <= op_q;
               prdata[FOPC_SWAP_BIT]           <= swap_q;
               prdata[FOPC_WRITE_ENABLE_BIT]           <= write_enable;
            end else if (paddr == FOPC_STAT_OFS) begin
               prdata[0] <= op_blocked;
               prdata[1] <= ecc_bypass;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   fopc_decode u_dec (
      .op_code      (op_q),
      .swap         (swap_q),
      .addr         (flash_address),
      .page_protect (page_protect),
      .ecc_cfg      (dynamic_ecc_config),
      .act          (act),
      .ecc_skip     (ecc_skip),
      .blocked      (blocked)
   );

   // Alias outputs follow the swap bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lower_alias_bank2 <= FOPC_SWAP_RST;
         upper_alias_bank2 <= ~FOPC_SWAP_RST;
      end else begin
         lower_alias_bank2 <= swap_q;
         upper_alias_bank2 <= ~swap_q;
      end
   end

   // Issue one action per start pulse while write enable is set; reserved codes issue nothing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_action <= 3'h0;
         flash_go     <= 1'b0;
         ecc_bypass   <= 1'b0;
         op_blocked   <= 1'b0;
      end else begin
         flash_go <= 1'b0;
         if (op_start && write_enable) begin
            flash_action <= act;
            flash_go     <= (act != FOPC_ACT_NONE);
            ecc_bypass   <= ecc_skip;
            op_blocked   <= blocked;
         end
      end
   end
endmodule

// ### pkg/fopc_pkg.sv
// Package with register offsets, field positions, operation codes and reset values for flash_op_control.
// Summary of operation
// - Swap bit 6 writable only when write enable is zero and unlock was performed.
// - Swap one maps bank 2 to lower alias, bank 1 upper; zero the reverse.
// - Operation field bits 3-0 writable only while write enable is zero.
// - Code 0111 erases whole array only if all 24 page protect bits are zero.
// - Code 0110 erases upper region, 0101 lower region, when region is unprotected.
// - Code 0100 erases the addressed page unless that page is write-protected.
// - Code 0011 programs the addressed row unless it is write-protected.
// - Code 0010 programs one 128-bit word at the address unless protected.
// - Code 0001 programs one word unless protected; code 0000 does nothing.
// - Single-word program acts as no operation when dynamic ECC setting is 00.
// - Other ECC settings run single-word program without writing ECC bits.
// - Bits 5 and 4 always read zero and ignore writes.
package fopc_pkg;

   // Register byte offsets.
   localparam logic [11:0] FOPC_CTRL_OFS   = 12'h000;
   localparam logic [11:0] FOPC_STAT_OFS   = 12'h004;

   // Control register field positions.
   localparam int FOPC_OP_LSB   = 0;
   localparam int FOPC_OP_MSB   = 3;
   localparam int FOPC_SWAP_BIT = 6;
   localparam int FOPC_WRITE_ENABLE_BIT = 14;
   localparam int FOPC_START_BIT = 15;

   // Reset values.
   localparam logic [3:0]  FOPC_OP_RST   = 4'h0;
   localparam logic        FOPC_SWAP_RST = 1'b0;

   // Page protect and ECC widths and values.
   localparam int          FOPC_PP_W      = 24;
   localparam logic [1:0]  FOPC_ECC_ALWAYS = 2'h0;

   // Address widths: region select bit and a page-number slice.
   localparam int FOPC_ADDR_W     = 32;
   localparam int FOPC_REGION_BIT = 19;
   localparam int FOPC_PAGE_LSB   = 14;

   // Operation codes.
   typedef enum logic [3:0] {
      FOPC_OP_NOP    = 4'h0,
      FOPC_OP_WORD   = 4'h1,
      FOPC_OP_QUAD   = 4'h2,
      FOPC_OP_ROW    = 4'h3,
      FOPC_OP_PAGE   = 4'h4,
      FOPC_OP_LOWER  = 4'h5,
      FOPC_OP_UPPER  = 4'h6,
      FOPC_OP_CHIP   = 4'h7
   } fopc_op_t;

   // Actions issued to the flash array.
   typedef enum logic [2:0] {
      FOPC_ACT_NONE, FOPC_ACT_WORD, FOPC_ACT_QUAD, FOPC_ACT_ROW,
      FOPC_ACT_PAGE, FOPC_ACT_LOWER, FOPC_ACT_UPPER, FOPC_ACT_CHIP
   } fopc_act_t;

endpackage

// ### src/fopc_decode.sv
// Operation decoder: turns a started code into an action with protection checks.
`timescale 1ns/10ps
module fopc_decode (
   // Request.
   input  wire logic [3:0]                  op_code,
   input  wire logic                        swap,
   input  wire logic [31:0]                 addr,
   input  wire logic [fopc_pkg::FOPC_PP_W-1:0] page_protect,
   input  wire logic [1:0]                  ecc_cfg,
   // Result.
   output fopc_pkg::fopc_act_t              act,
   output logic                             ecc_skip,
   output logic                             blocked
);
   import fopc_pkg::*;

   logic [FOPC_PP_W-1:0] half_mask;
   logic                 page_prot;

   // Page protect covers pages from the bottom; half the bits belong to each region.
   assign half_mask  = {{(FOPC_PP_W/2){1'b0}}, {(FOPC_PP_W/2){1'b1}}};
   // The page index is the address above the page offset, zero-extended to the limit's width.
   // Slicing a fixed width would run past the top of the address, so it is padded instead.
   assign page_prot  = ({{(FOPC_PP_W-FOPC_ADDR_W+FOPC_PAGE_LSB){1'b0}},
                         addr[FOPC_ADDR_W-1:FOPC_PAGE_LSB]} < page_protect);

   // Action select with per-code protection.
   always_comb begin
      act      = FOPC_ACT_NONE;
      ecc_skip = 1'b0;
      blocked  = 1'b0;
      case (op_code)
         FOPC_OP_NOP: begin
            act = FOPC_ACT_NONE;
         end
         FOPC_OP_WORD: begin
            if (ecc_cfg == FOPC_ECC_ALWAYS) begin
               act = FOPC_ACT_NONE;
            end else if (page_prot) begin
               blocked = 1'b1;
            end else begin
               act      = FOPC_ACT_WORD;
               ecc_skip = 1'b1;
            end
         end
         FOPC_OP_QUAD: begin
            if (page_prot) blocked = 1'b1;
            else act = FOPC_ACT_QUAD;
         end
         FOPC_OP_ROW: begin
            if (page_prot) blocked = 1'b1;
            else act = FOPC_ACT_ROW;
         end
         FOPC_OP_PAGE: begin
            if (page_prot) blocked = 1'b1;
            else act = FOPC_ACT_PAGE;
         end
         FOPC_OP_LOWER: begin
            // Lower mapped region is the physically lower half unless swapped.
            if (!swap && |(page_protect & half_mask)) blocked = 1'b1;
            else if (swap && |(page_protect & ~half_mask)) blocked = 1'b1;
            else act = FOPC_ACT_LOWER;
         end
         FOPC_OP_UPPER: begin
            if (swap && |(page_protect & half_mask)) blocked = 1'b1;
            else if (!swap && |(page_protect & ~half_mask)) blocked = 1'b1;
            else act = FOPC_ACT_UPPER;
         end
         FOPC_OP_CHIP: begin
            if (page_protect != '0) blocked = 1'b1;
            else act = FOPC_ACT_CHIP;
         end
         default: begin
            act = FOPC_ACT_NONE;
         end
      endcase
   end
endmodule

// ### dv/fopc_sva.sv
// Port-level checker for the flash operation control block.
`timescale 1ns/10ps
module fopc_sva (
   // Clock, reset and bus.
   input wire logic                             pclk,
   input wire logic                             presetn,
   input wire logic                             psel,
   input wire logic                             penable,
   input wire logic                             pwrite,
   input wire logic [11:0]                      paddr,
   input wire logic [31:0]                      prdata,
   input wire logic                             pready,
   // Neighbour inputs.
   input wire logic                             write_enable,
   input wire logic                             unlocked,
   input wire logic [fopc_pkg::FOPC_PP_W-1:0]   page_protect,
   input wire logic [1:0]                       dynamic_ecc_config,
   input wire logic                             op_start,
   // Array side.
   input wire logic                             lower_alias_bank2,
   input wire logic                             upper_alias_bank2,
   input wire logic [2:0]                       flash_action,
   input wire logic                             flash_go,
   input wire logic                             ecc_bypass
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Both aliases must always name different banks.
   a_alias_pair: assert property (lower_alias_bank2 != upper_alias_bank2)
      else $error("alias outputs equal");
   a_swap_gate: assert property ($changed(lower_alias_bank2) |->
      $past(psel && penable && pwrite && paddr == 12'h000 && !write_enable && unlocked, 2))
      else $error("swap changed without a permitted write");
   a_swap_read: assert property (pready && !pwrite && paddr == 12'h000 |->
      prdata[6] == lower_alias_bank2) else $error("swap read differs from alias");
   a_rsvd_bits: assert property (pready && !pwrite && paddr == 12'h000 |->
      prdata[5:4] == 2'b00) else $error("unimplemented bits read nonzero");
   // An issued action needs a start while writes are enabled.
   a_go_cause: assert property (flash_go |-> $past(op_start && write_enable))
      else $error("action issued without start");
   a_chip_prot: assert property (flash_go && flash_action == 3'h7 |->
      $past(page_protect) == 24'h000000) else $error("chip erase with protection");
   a_word_ecc: assert property (flash_go && flash_action == 3'h1 |->
      $past(dynamic_ecc_config) != 2'b00) else $error("word program with ECC always on");
   a_word_bypass: assert property (flash_go && flash_action == 3'h1 |-> ecc_bypass)
      else $error("word program without ECC bypass");
endmodule

// ### dv/testbench.sv
// Self-checking bench for the flash operation control block.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
   import fopc_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        write_enable = 1'b0, unlocked = 1'b0, op_start = 1'b0, err, swap_e;
   logic        lower_alias_bank2, upper_alias_bank2, pready, pslverr, flash_go;
   logic        ecc_bypass, op_blocked;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, flash_address = 32'h0, prdata, rd, fa;
   logic [23:0] page_protect = 24'h0, pp;
   logic [1:0]  dynamic_ecc_config = 2'h1, ec;
   logic [2:0]  flash_action;
   logic [3:0]  op_e, ea;
   int          err_total = 0, n_compared = 0, i, k;
   // Free-running bus clock.
   always #5 pclk = ~pclk;
   fopc_top fopc_top_i (
      .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite),
      .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .pready (pready), .pslverr (pslverr),
      .write_enable (write_enable), .unlocked (unlocked), .flash_address (flash_address),
      .page_protect (page_protect), .dynamic_ecc_config (dynamic_ecc_config),
      .op_start (op_start), .lower_alias_bank2 (lower_alias_bank2),
      .upper_alias_bank2 (upper_alias_bank2), .flash_action (flash_action),
      .flash_go (flash_go), .ecc_bypass (ecc_bypass), .op_blocked (op_blocked)
   );
   task end_of_test;
      if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One bus transfer; the request is held until pready is seen at an edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin err_total++; end_of_test; end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Expected {blocked, action}; a refused or empty start issues nothing.
   // The lower region owns the low half of the protect bits unless the banks are swapped.
   function logic [3:0] exp_op(logic [3:0] c, logic [23:0] p, logic [31:0] a, logic [1:0] e,
                               logic s);
      logic        prot;
      logic [11:0] lo, hi;
      prot = {6'h00, a[31:14]} < p;
      lo = s ? p[23:12] : p[11:0];
      hi = s ? p[11:0] : p[23:12];
      case (c)
         4'h1: exp_op = (e == 2'h0) ? 4'h0 : (prot ? 4'h8 : 4'h1);
         4'h2, 4'h3, 4'h4: exp_op = prot ? 4'h8 : {1'b0, c[2:0]};
         4'h5: exp_op = (lo != 12'h000) ? 4'h8 : 4'h5;
         4'h6: exp_op = (hi != 12'h000) ? 4'h8 : 4'h6;
         4'h7: exp_op = (p != 24'h0) ? 4'h8 : 4'h7;
         default: exp_op = 4'h0;
      endcase
   endfunction
   // Main sequence: reset, gated writes, then every code started.
   initial begin
      k = $urandom(38);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      `CHK("lower", 1'b0, lower_alias_bank2)
      apb(1'b1, 12'h008, 32'hFFFFFFFF);
      `CHK("slverr", 1'b1, err)
      swap_e = 1'b0;
      op_e = 4'h0;
      for (i = 0; i < 40; i++) begin
         k = $urandom;
         write_enable <= k[8];
         unlocked <= k[9];
         apb(1'b1, 12'h000, {24'h0, k[7:0]});
         if (!k[8]) op_e = k[3:0];
         if (!k[8] && k[9]) swap_e = k[6];
         apb(1'b0, 12'h000, 32'h0);
         `CHK("ctrl", {k[8], 7'h00, swap_e, 2'b00, op_e}, rd[14:0])
         `CHK("alias", swap_e, lower_alias_bank2)
         `CHK("upper", ~swap_e, upper_alias_bank2)
      end
      for (i = 0; i < 48; i++) begin
         k = $urandom;
         fa = $urandom;
         ec = k[13:12];
         pp = k[0] ? 24'h0 : {6'h00, k[31:14]};
         if (i[2:0] >= 3'h5 && pp != 24'h0) pp = k[1] ? 24'h000FFF : 24'hFFF000;
         write_enable <= 1'b0;
         apb(1'b1, 12'h000, {25'h0, k[6], 2'b00, i[3:0]});
         if (unlocked) swap_e = k[6];
         flash_address <= fa;
         page_protect <= pp;
         dynamic_ecc_config <= ec;
         write_enable <= 1'b1;
         @(posedge pclk);
         op_start <= 1'b1;
         @(posedge pclk);
         op_start <= 1'b0;
         #1;
         ea = exp_op(i[3:0], pp, fa, ec, swap_e);
         `CHK("action", ea[2:0], flash_go ? flash_action : 3'h0)
         if (ea[2:0] == 3'h1) `CHK("bypass", 1'b1, ecc_bypass)
         `CHK("blocked", ea[3], op_blocked)
         apb(1'b0, 12'h004, 32'h0);
         `CHK("status", {ea[2:0] == 3'h1, ea[3]}, rd[1:0])
      end
      // Reset in mid-run: every output but ecc_bypass and op_blocked is checked at its idle value, and the register clears.
      presetn <= 1'b0;
      write_enable <= 1'b0;
      @(posedge pclk);
      #1;
      `CHK("reset", 8'h01, {flash_action, lower_alias_bank2, flash_go, pready, pslverr, upper_alias_bank2})
      `CHK("rdata", 32'h0, prdata)
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      end_of_test;
   end
endmodule
bind fopc_top fopc_sva fopc_sva_i (
   .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite),
   .paddr (paddr), .prdata (prdata), .pready (pready), .write_enable (write_enable),
   .unlocked (unlocked), .page_protect (page_protect),
   .dynamic_ecc_config (dynamic_ecc_config), .op_start (op_start),
   .lower_alias_bank2 (lower_alias_bank2), .upper_alias_bank2 (upper_alias_bank2),
   .flash_action (flash_action), .flash_go (flash_go), .ecc_bypass (ecc_bypass)
);
